// ---- inc/rcs_pkg.sv ----
// constants of the counter control and status register block
// assumes AXI4-Lite with 32-bit data, one register per aligned word
package rcs_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0]  RCS_IDX_CTRL     = 6'h00;
  localparam logic [5:0]  RCS_IDX_SYNC     = 6'h01;
  localparam logic [5:0]  RCS_IDX_IRQ_EN   = 6'h02;
  localparam logic [5:0]  RCS_IDX_FLAGS    = 6'h03;
  localparam logic [5:0]  RCS_IDX_LATCH    = 6'h04;
  localparam logic [5:0]  RCS_IDX_DEBUG    = 6'h05;
  localparam logic [5:0]  RCS_IDX_TRIM     = 6'h06;
  localparam logic [5:0]  RCS_IDX_CNT_LO   = 6'h08;
  localparam logic [5:0]  RCS_IDX_CNT_HI   = 6'h09;
  localparam logic [5:0]  RCS_IDX_PER_LO   = 6'h0A;
  localparam logic [5:0]  RCS_IDX_PER_HI   = 6'h0B;
  localparam logic [5:0]  RCS_IDX_CMP_LO   = 6'h0C;
  localparam logic [5:0]  RCS_IDX_CMP_HI   = 6'h0D;
  // control and trim field positions
  localparam int          RCS_CTRL_ON_BIT  = 0;
  localparam int          RCS_CTRL_COR_BIT = 2;
  localparam int          RCS_CTRL_DIV_LSB = 3;
  localparam int          RCS_CTRL_SBY_BIT = 7;
  localparam int          RCS_TRIM_SGN_BIT = 7;
  // flag and enable positions
  localparam int          RCS_WRAP_BIT     = 0;
  localparam int          RCS_MATCH_BIT    = 1;
  // sync channels
  localparam int          RCS_SYNC_CH      = 4;
  localparam int          RCS_SY_CTRL      = 0;
  localparam int          RCS_SY_CNT       = 1;
  localparam int          RCS_SY_PER       = 2;
  localparam int          RCS_SY_CMP       = 3;
  localparam logic [1:0]  RCS_SYNC_TICKS   = 2'h2;
  // reset values
  localparam logic [7:0]  RCS_RST_BYTE     = 8'h00;
  localparam logic [15:0] RCS_RST_CNT      = 16'h0000;
  localparam logic [15:0] RCS_RST_PER      = 16'hFFFF;
  localparam logic [15:0] RCS_RST_CMP      = 16'h0000;
  // correction interval in counter clock cycles
  localparam int          RCS_PPM_INTERVAL = 1000000;
  // bus responses
  localparam logic [1:0]  RCS_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RCS_RESP_SLVERR  = 2'h2;
endpackage

// ---- design/rcs_sync.sv ----
// busy tracking of values crossing into the counter clock
// assumes tick_in is one pulse per counter clock cycle
`timescale 1ns/1ps
module rcs_sync
(
  input  wire logic                            mclk_in,   // system clock
  input  wire logic                            nrst_in,   // sync reset, low
  input  wire logic                            tick_in,   // counter clock pulse
  input  wire logic [rcs_pkg::RCS_SYNC_CH-1:0] load_in,   // new value written
  output logic      [rcs_pkg::RCS_SYNC_CH-1:0] busy_out,  // transfer pending
  output logic      [rcs_pkg::RCS_SYNC_CH-1:0] apply_out  // value takes effect
);
  import rcs_pkg::*;

  genvar g;
  generate
    for (g = 0; g < RCS_SYNC_CH; g++)
    begin : g_ch
      logic [1:0] seen_reg;
      logic       busy_reg;
      // last of the counted ticks releases the value
      assign apply_out[g] = busy_reg && tick_in && !load_in[g] &&
                            (seen_reg == RCS_SYNC_TICKS - 2'h1);
      assign busy_out[g]  = busy_reg;
      always_ff @(posedge mclk_in)
      begin
        if (!nrst_in)
        begin
          busy_reg <= 1'b0;
          seen_reg <= 2'h0;
        end
        else if (load_in[g])
        begin
          busy_reg <= 1'b1;
          seen_reg <= 2'h0;
        end
        else if (apply_out[g])
          busy_reg <= 1'b0;
        else if (busy_reg && tick_in)
          seen_reg <= seen_reg + 2'h1;
      end
    end
  endgenerate
endmodule // rcs_sync

// ---- design/rcs_prescaler.sv ----
// power-of-two prescaler with ppm correction
// assumes tick_in already gated by the run conditions
`timescale 1ns/1ps
module rcs_prescaler
#(
  parameter int PPM_CYC = rcs_pkg::RCS_PPM_INTERVAL
)
(
  input  wire logic       mclk_in,     // system clock
  input  wire logic       nrst_in,     // sync reset, low
  input  wire logic       tick_in,     // counter clock pulse
  input  wire logic [3:0] div_code_in, // divide by 2**code
  input  wire logic       corr_on_in,  // correction enabled
  input  wire logic       sign_in,     // 1 speeds up
  input  wire logic [6:0] error_in,    // clocks per interval
  output logic            tick_out     // prescaled pulse
);
  import rcs_pkg::*;

  logic [15:0] div_cnt_reg;
  logic [19:0] ppm_cnt_reg;
  logic [6:0]  done_reg;
  logic [15:0] mask;
  logic [15:0] sum;
  logic [15:0] step;
  logic        need_corr;
  logic        ppm_end;

  assign mask      = (16'h0001 << div_code_in) - 16'h0001;
  assign need_corr = corr_on_in && (done_reg < error_in);
  // slower drops a step, faster takes two
  assign step      = need_corr ? (sign_in ? 16'h0002 : 16'h0000) : 16'h0001;
  assign sum       = div_cnt_reg + step;
  assign tick_out  = tick_in && (sum > mask);
  assign ppm_end   = ppm_cnt_reg == 20'(PPM_CYC - 1);

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      div_cnt_reg <= 16'h0000;
    else if (tick_out)
      div_cnt_reg <= (mask == 16'h0000) ? 16'h0000 : sum - mask - 16'h0001;
    else if (tick_in)
      div_cnt_reg <= sum;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ppm_cnt_reg <= 20'h00000;
      done_reg    <= 7'h00;
    end
    else if (tick_in && ppm_end)
    begin
      ppm_cnt_reg <= 20'h00000;
      done_reg    <= 7'h00;
    end
    else if (tick_in)
    begin
      ppm_cnt_reg <= ppm_cnt_reg + 20'h00001;
      if (need_corr)
        done_reg <= done_reg + 7'h01;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  property p_div1;
    (tick_in && div_code_in == 4'h0 && !corr_on_in) |-> tick_out;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided tick missing");

  property p_plain_step;
    (tick_in && !tick_out && !corr_on_in) |=> div_cnt_reg == $past(div_cnt_reg) + 16'h0001;
  endproperty
  a_plain_step: assert property (p_plain_step) else $error("uncorrected step not one");

  property p_interval_end;
    (tick_in && ppm_end) |=> (done_reg == 7'h00 && ppm_cnt_reg == 20'h00000);
  endproperty
  a_interval_end: assert property (p_interval_end) else $error("interval did not restart");
endmodule // rcs_prescaler

// ---- design/rcs_regs.sv ----
// control, status, flag and trim registers of a 16-bit counter
// assumes an AXI4-Lite master and a counter clock given as tick pulses
`timescale 1ns/1ps
module rcs_regs
#(
  parameter int PPM_CYC = rcs_pkg::RCS_PPM_INTERVAL
)
(
  input  wire logic        mclk_in,          // 250 MHz clock
  input  wire logic        nrst_in,          // sync reset, low
  input  wire logic [7:0]  s_axi_awaddr,     // write address
  input  wire logic [2:0]  s_axi_awprot,     // unused
  input  wire logic        s_axi_awvalid,    // write address valid
  output logic             s_axi_awready,    // write address ready
  input  wire logic [31:0] s_axi_wdata,      // write data
  input  wire logic [3:0]  s_axi_wstrb,      // byte enables
  input  wire logic        s_axi_wvalid,     // write data valid
  output logic             s_axi_wready,     // write data ready
  output logic [1:0]       s_axi_bresp,      // write response
  output logic             s_axi_bvalid,     // write response valid
  input  wire logic        s_axi_bready,     // write response ready
  input  wire logic [7:0]  s_axi_araddr,     // read address
  input  wire logic [2:0]  s_axi_arprot,     // unused
  input  wire logic        s_axi_arvalid,    // read address valid
  output logic             s_axi_arready,    // read address ready
  output logic [31:0]      s_axi_rdata,      // read data
  output logic [1:0]       s_axi_rresp,      // read response
  output logic             s_axi_rvalid,     // read data valid
  input  wire logic        s_axi_rready,     // read data ready
  input  wire logic        rtc_tick_in,      // counter clock pulse
  input  wire logic        standby_in,       // standby sleep active
  input  wire logic        cpu_halted_in,    // processor in break
  output logic             irq_out,          // interrupt request
  output logic             match_evt_out,    // compare event pulse
  output logic             wrap_evt_out      // overflow event pulse
);
  import rcs_pkg::*;

  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_eff_reg;
  logic [1:0]  irq_en_reg;
  logic [1:0]  flags_reg;
  logic [1:0]  flags_next;
  logic [7:0]  latch_reg;
  logic        dbg_run_reg;
  logic [7:0]  trim_reg;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_wr_reg;
  logic [15:0] per_reg;
  logic [15:0] per_eff_reg;
  logic [15:0] cmp_reg;
  logic [15:0] cmp_eff_reg;
  logic        aw_held_reg;
  logic [5:0]  aw_idx_reg;
  logic        w_held_reg;
  logic [7:0]  w_byte_reg;
  logic        w_lane_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        rvalid_reg;
  logic [7:0]  rdata_reg;
  logic [1:0]  rresp_reg;
  logic        match_evt_reg;
  logic        wrap_evt_reg;
  logic        do_write;
  logic        wr_ok;
  logic        wr_en;
  logic        rd_take;
  logic [5:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic        rd_ok;
  logic        run;
  logic        presc_tick;
  logic        wrap;
  logic        match;
  logic [15:0] cnt_next;
  logic [1:0]  flag_clr;
  logic [RCS_SYNC_CH-1:0] sync_load;
  logic [RCS_SYNC_CH-1:0] sync_busy;
  logic [RCS_SYNC_CH-1:0] sync_apply;

  function automatic logic idx_mapped(input logic [5:0] idx);
    idx_mapped = (idx <= RCS_IDX_TRIM) || ((idx >= RCS_IDX_CNT_LO) && (idx <= RCS_IDX_CMP_HI));
  endfunction

  // write channel: address and data taken in either order
  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_ok         = idx_mapped(aw_idx_reg);
  assign wr_en         = do_write && wr_ok && w_lane_reg;

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      aw_held_reg <= 1'b0;
      aw_idx_reg  <= 6'h00;
      w_held_reg  <= 1'b0;
      w_byte_reg  <= 8'h00;
      w_lane_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RCS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_idx_reg  <= s_axi_awaddr[7:2];
      end
      else if (do_write)
        aw_held_reg <= 1'b0;
      if (s_axi_wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_byte_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_held_reg <= 1'b0;
      if (do_write)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? RCS_RESP_OKAY : RCS_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // read channel
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign rd_take       = s_axi_arvalid && !rvalid_reg;
  assign rd_idx        = s_axi_araddr[7:2];
  assign rd_ok         = idx_mapped(rd_idx);

  always_comb
  begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      RCS_IDX_CTRL:   rd_byte = ctrl_reg;
      RCS_IDX_SYNC:   rd_byte = {4'h0, sync_busy};
      RCS_IDX_IRQ_EN: rd_byte = {6'h00, irq_en_reg};
      RCS_IDX_FLAGS:  rd_byte = {6'h00, flags_reg};
      RCS_IDX_LATCH:  rd_byte = latch_reg;
      RCS_IDX_DEBUG:  rd_byte = {7'h00, dbg_run_reg};
      RCS_IDX_TRIM:   rd_byte = trim_reg;
      RCS_IDX_CNT_LO: rd_byte = cnt_reg[7:0];
      RCS_IDX_PER_LO: rd_byte = per_reg[7:0];
      RCS_IDX_CMP_LO: rd_byte = cmp_reg[7:0];
      RCS_IDX_CNT_HI, RCS_IDX_PER_HI, RCS_IDX_CMP_HI: rd_byte = latch_reg;
      default:        rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      rresp_reg  <= RCS_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_byte;
      rresp_reg  <= rd_ok ? RCS_RESP_OKAY : RCS_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // shared byte latch: low-byte write fills it, low-byte read snapshots high byte
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      latch_reg <= RCS_RST_BYTE;
    else if (rd_take && rd_idx == RCS_IDX_CNT_LO)
      latch_reg <= cnt_reg[15:8];
    else if (rd_take && rd_idx == RCS_IDX_PER_LO)
      latch_reg <= per_reg[15:8];
    else if (rd_take && rd_idx == RCS_IDX_CMP_LO)
      latch_reg <= cmp_reg[15:8];
    else if (wr_en && (aw_idx_reg == RCS_IDX_LATCH || aw_idx_reg == RCS_IDX_CNT_LO ||
                       aw_idx_reg == RCS_IDX_PER_LO || aw_idx_reg == RCS_IDX_CMP_LO))
      latch_reg <= w_byte_reg;
  end

  // software registers
  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ctrl_reg    <= RCS_RST_BYTE;
      irq_en_reg  <= 2'h0;
      dbg_run_reg <= 1'b0;
      trim_reg    <= RCS_RST_BYTE;
      cnt_wr_reg  <= RCS_RST_CNT;
      per_reg     <= RCS_RST_PER;
      cmp_reg     <= RCS_RST_CMP;
    end
    else if (wr_en)
    begin
      unique case (aw_idx_reg)
        RCS_IDX_CTRL:   ctrl_reg    <= w_byte_reg;
        RCS_IDX_IRQ_EN: irq_en_reg  <= w_byte_reg[1:0];
        RCS_IDX_DEBUG:  dbg_run_reg <= w_byte_reg[0];
        RCS_IDX_TRIM:   trim_reg    <= w_byte_reg;
        RCS_IDX_CNT_HI: cnt_wr_reg  <= {w_byte_reg, latch_reg};
        RCS_IDX_PER_HI: per_reg     <= {w_byte_reg, latch_reg};
        RCS_IDX_CMP_HI: cmp_reg     <= {w_byte_reg, latch_reg};
        default:        ;
      endcase
    end
  end

  // crossing into the counter clock
  always_comb
  begin
    sync_load              = '0;
    sync_load[RCS_SY_CTRL] = wr_en && aw_idx_reg == RCS_IDX_CTRL;
    sync_load[RCS_SY_CNT]  = wr_en && aw_idx_reg == RCS_IDX_CNT_HI;
    sync_load[RCS_SY_PER]  = wr_en && aw_idx_reg == RCS_IDX_PER_HI;
    sync_load[RCS_SY_CMP]  = wr_en && aw_idx_reg == RCS_IDX_CMP_HI;
  end

  rcs_sync u_sync (
    .mclk_in   (mclk_in),
    .nrst_in   (nrst_in),
    .tick_in   (rtc_tick_in),
    .load_in   (sync_load),
    .busy_out  (sync_busy),
    .apply_out (sync_apply)
  );

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      ctrl_eff_reg <= RCS_RST_BYTE;
      per_eff_reg  <= RCS_RST_PER;
      cmp_eff_reg  <= RCS_RST_CMP;
    end
    else
    begin
      if (sync_apply[RCS_SY_CTRL])
        ctrl_eff_reg <= ctrl_reg;
      if (sync_apply[RCS_SY_PER])
        per_eff_reg <= per_reg;
      if (sync_apply[RCS_SY_CMP])
        cmp_eff_reg <= cmp_reg;
    end
  end

  // counter core
  assign run = ctrl_eff_reg[RCS_CTRL_ON_BIT]
               && !(standby_in && !ctrl_eff_reg[RCS_CTRL_SBY_BIT])
               && !(cpu_halted_in && !dbg_run_reg);

  rcs_prescaler #(
    .PPM_CYC (PPM_CYC)
  ) u_presc (
    .mclk_in     (mclk_in),
    .nrst_in     (nrst_in),
    .tick_in     (rtc_tick_in && run),
    .div_code_in (ctrl_eff_reg[RCS_CTRL_DIV_LSB +: 4]),
    .corr_on_in  (ctrl_eff_reg[RCS_CTRL_COR_BIT]),
    .sign_in     (trim_reg[RCS_TRIM_SGN_BIT]),
    .error_in    (trim_reg[6:0]),
    .tick_out    (presc_tick)
  );

  assign wrap     = presc_tick && (cnt_reg == per_eff_reg);
  assign cnt_next = wrap ? 16'h0000 : cnt_reg + 16'h0001;
  assign match    = presc_tick && (cnt_next == cmp_eff_reg);

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
      cnt_reg <= RCS_RST_CNT;
    else if (sync_apply[RCS_SY_CNT])
      cnt_reg <= cnt_wr_reg;
    else if (presc_tick)
      cnt_reg <= cnt_next;
  end

  // flags: a set in the clearing cycle wins
  assign flag_clr   = (wr_en && aw_idx_reg == RCS_IDX_FLAGS) ? w_byte_reg[1:0] : 2'h0;
  assign flags_next = {match, wrap} | (flags_reg & ~flag_clr);

  always_ff @(posedge mclk_in)
  begin
    if (!nrst_in)
    begin
      flags_reg     <= 2'h0;
      match_evt_reg <= 1'b0;
      wrap_evt_reg  <= 1'b0;
    end
    else
    begin
      flags_reg     <= flags_next;
      match_evt_reg <= match;
      wrap_evt_reg  <= wrap;
    end
  end

  assign irq_out       = |(flags_reg & irq_en_reg);
  assign match_evt_out = match_evt_reg;
  assign wrap_evt_out  = wrap_evt_reg;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  property p_ctrl_latency;
    $changed(ctrl_eff_reg) |-> $past(sync_busy[RCS_SY_CTRL]) && $past(rtc_tick_in);
  endproperty
  a_ctrl_latency: assert property (p_ctrl_latency) else $error("control applied early");

  property p_ctrl_busy;
    sync_load[RCS_SY_CTRL] |=> sync_busy[RCS_SY_CTRL] && !sync_apply[RCS_SY_CTRL];
  endproperty
  a_ctrl_busy: assert property (p_ctrl_busy) else $error("control busy not raised");

  property p_cmp_busy;
    sync_load[RCS_SY_CMP] ##1 !rtc_tick_in [*2] |=> sync_busy[RCS_SY_CMP];
  endproperty
  a_cmp_busy: assert property (p_cmp_busy) else $error("compare busy dropped early");

  property p_standby;
    (standby_in && !ctrl_eff_reg[RCS_CTRL_SBY_BIT]) |=> $stable(cnt_reg) || $past(sync_apply[RCS_SY_CNT]);
  endproperty
  a_standby: assert property (p_standby) else $error("counter ran in standby");

  property p_off_hold;
    !ctrl_eff_reg[RCS_CTRL_ON_BIT] |=> (flags_reg & ~$past(flags_reg)) == 2'h0;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("disabled counter set a flag");

  property p_break;
    (cpu_halted_in && !dbg_run_reg) |=> !match_evt_out && !wrap_evt_out;
  endproperty
  a_break: assert property (p_break) else $error("event during break halt");

  property p_wrap;
    wrap |=> flags_reg[RCS_WRAP_BIT] && (cnt_reg == 16'h0000 || $past(sync_apply[RCS_SY_CNT]));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not set flag");

  property p_match;
    match |=> flags_reg[RCS_MATCH_BIT] ##0 match_evt_out;
  endproperty
  a_match: assert property (p_match) else $error("match did not set flag");

  property p_w1c;
    (flag_clr[RCS_MATCH_BIT] && !match) |=> !flags_reg[RCS_MATCH_BIT];
  endproperty
  a_w1c: assert property (p_w1c) else $error("one did not clear flag");

  property p_irq;
    (flags_reg[RCS_WRAP_BIT] && irq_en_reg[RCS_WRAP_BIT]) |-> irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_latch;
    (rd_take && rd_idx == RCS_IDX_CNT_LO) |=> latch_reg == $past(cnt_reg[15:8]);
  endproperty
  a_latch: assert property (p_latch) else $error("high byte not latched");

  c_wrap: cover property (wrap ##1 irq_out);
  c_match: cover property (match);
  c_ctrl_sync: cover property (sync_load[RCS_SY_CTRL] ##[1:20] sync_apply[RCS_SY_CTRL]);
  c_clear: cover property (flags_reg[RCS_WRAP_BIT] ##1 !flags_reg[RCS_WRAP_BIT]);
endmodule // rcs_regs

// ---- bench/rcs_regs_bench.sv ----
// self-checking bench of the counter control and status registers
// assumes rcs_pkg compiled first; counter clock given as tick pulses
`timescale 1ns/1ps
module rcs_regs_bench;
  import rcs_pkg::*;
  typedef struct {logic w; logic [5:0] i; logic [7:0] d; logic [1:0] r;} rcs_row_type;
  localparam logic [1:0] OK = RCS_RESP_OKAY;
  localparam logic [1:0] ER = RCS_RESP_SLVERR;
  logic        mclk_in, nrst_in, rtc_tick_in, standby_in, cpu_halted_in, irq_out, match_evt_out, wrap_evt_out;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, q, c0, c1;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          bad_count, n_compared, n_match, n_wrap;
  rcs_row_type rows [16];
  rcs_regs #(.PPM_CYC(64)) u_rcs_regs (.mclk_in, .nrst_in, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rtc_tick_in, .standby_in, .cpu_halted_in, .irq_out, .match_evt_out,
    .wrap_evt_out);
  initial
  begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // event pulses seen by an outside user
  always @(posedge mclk_in)
  begin
    if (match_evt_out === 1'b1) n_match++;
    if (wrap_evt_out === 1'b1) n_wrap++;
  end
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic limit(input int t);
    if (t > 500)
    begin
      bad_count++;
      $display("[FAIL] %0t bus wait ran out", $time);
      conclude();
    end
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] r = OK);
    logic a, b, v;
    logic [1:0] rs;
    int t;
    t = 0;
    @(posedge mclk_in);
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(negedge mclk_in);
      a = s_axi_awready;
      b = s_axi_wready;
      v = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge mclk_in);
      if (a) s_axi_awvalid <= 1'b0;
      if (b) s_axi_wvalid <= 1'b0;
      t++;
      limit(t);
    end while (!v);
    s_axi_bready <= 1'b0;
    check({6'h00, rs}, {6'h00, r});
  endtask
  task automatic rd(input logic [5:0] i, output logic [7:0] d, input logic [1:0] r = OK);
    logic a, v;
    logic [1:0] rs;
    int t;
    t = 0;
    @(posedge mclk_in);
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(negedge mclk_in);
      a = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata[7:0];
      rs = s_axi_rresp;
      @(posedge mclk_in);
      if (a) s_axi_arvalid <= 1'b0;
      t++;
      limit(t);
    end while (!v);
    s_axi_rready <= 1'b0;
    check({6'h00, rs}, {6'h00, r});
  endtask
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge mclk_in);
      rtc_tick_in <= 1'b1;
      @(posedge mclk_in);
      rtc_tick_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
  endtask
  // counter advance over n counter ticks
  task automatic dcnt(input int n, input logic [7:0] e);
    rd(RCS_IDX_CNT_LO, c0);
    pulse(n);
    rd(RCS_IDX_CNT_LO, c1);
    check(c1 - c0, e);
  endtask
  initial
  begin
    {nrst_in, rtc_tick_in, standby_in, cpu_halted_in, s_axi_awvalid, s_axi_wvalid} = 6'h00;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 9'h000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    bad_count = 0;
    n_compared = 0;
    rows = '{'{1'h0,6'h00,8'h00,OK}, '{1'h0,6'h01,8'h00,OK}, '{1'h0,6'h02,8'h00,OK}, '{1'h0,6'h03,8'h00,OK},
      '{1'h0,6'h04,8'h00,OK}, '{1'h0,6'h05,8'h00,OK}, '{1'h0,6'h06,8'h00,OK}, '{1'h0,6'h0A,8'hFF,OK},
      '{1'h0,6'h04,8'hFF,OK}, '{1'h0,6'h07,8'h00,ER}, '{1'h1,6'h07,8'h55,ER}, '{1'h1,6'h0E,8'h01,ER},
      '{1'h1,6'h04,8'hA5,OK}, '{1'h0,6'h04,8'hA5,OK}, '{1'h1,6'h06,8'h85,OK}, '{1'h0,6'h06,8'h85,OK}};
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    foreach (rows[k])
    begin
      if (rows[k].w) wr(rows[k].i, rows[k].d, rows[k].r);
      else
      begin
        rd(rows[k].i, q, rows[k].r);
        check(q, rows[k].d);
      end
    end
    wr(RCS_IDX_DEBUG, 8'h01);
    wr(RCS_IDX_IRQ_EN, 8'h03);
    wr(RCS_IDX_CTRL, 8'h01);
    pulse(1);
    rd(RCS_IDX_SYNC, q);
    check(q, 8'h01);
    pulse(1);
    rd(RCS_IDX_SYNC, q);
    check(q, 8'h00);
    dcnt(4, 8'h04);
    wr(RCS_IDX_CTRL, 8'h09);
    pulse(2);
    dcnt(8, 8'h04);
    standby_in <= 1'b1;
    dcnt(8, 8'h00);
    wr(RCS_IDX_CTRL, 8'h89);
    pulse(2);
    dcnt(8, 8'h04);
    standby_in <= 1'b0;
    cpu_halted_in <= 1'b1;
    dcnt(8, 8'h04);
    wr(RCS_IDX_DEBUG, 8'h00);
    dcnt(8, 8'h00);
    cpu_halted_in <= 1'b0;
    wr(RCS_IDX_TRIM, 8'h82);
    rd(RCS_IDX_SYNC, q);
    check(q, 8'h00);
    wr(RCS_IDX_CTRL, 8'h0D);
    pulse(66);
    dcnt(64, 8'h21);
    wr(RCS_IDX_TRIM, 8'h02);
    dcnt(64, 8'h1F);
    wr(RCS_IDX_CTRL, 8'h00);
    pulse(2);
    wr(RCS_IDX_CNT_LO, 8'h00);
    wr(RCS_IDX_CNT_HI, 8'h00);
    wr(RCS_IDX_PER_LO, 8'h05);
    wr(RCS_IDX_PER_HI, 8'h00);
    wr(RCS_IDX_CMP_LO, 8'h03);
    wr(RCS_IDX_CMP_HI, 8'h00);
    rd(RCS_IDX_SYNC, q);
    check(q, 8'h0E);
    pulse(2);
    rd(RCS_IDX_SYNC, q);
    check(q, 8'h00);
    dcnt(8, 8'h00);
    rd(RCS_IDX_FLAGS, q);
    check(q, 8'h00);
    wr(RCS_IDX_CTRL, 8'h01);
    pulse(14);
    rd(RCS_IDX_FLAGS, q);
    check(q, 8'h03);
    check(n_match[7:0], 8'h02);
    check(n_wrap[7:0], 8'h02);
    check({7'h00, irq_out}, 8'h01);
    wr(RCS_IDX_CTRL, 8'h00);
    pulse(2);
    wr(RCS_IDX_IRQ_EN, 8'h01);
    wr(RCS_IDX_FLAGS, 8'h01);
    rd(RCS_IDX_FLAGS, q);
    check(q, 8'h02);
    check({7'h00, irq_out}, 8'h00);
    wr(RCS_IDX_FLAGS, 8'h02);
    rd(RCS_IDX_FLAGS, q);
    check(q, 8'h00);
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    rd(RCS_IDX_TRIM, q);
    check(q, 8'h00);
    rd(RCS_IDX_PER_LO, q);
    check(q, 8'hFF);
    conclude();
  end
endmodule // rcs_regs_bench
